// [lct_device.sv]
// Device end: decodes transport commands, collects the packet, answers.
// Assumes host drives the link on mclk; securityLocked is a pin input.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lct_device #(
	parameter int DATA_SECTORS = 1
) (
	input  wire logic   mclk,
	input  wire logic   rst_b,
	lct_link_if.dev     link,
	input  wire logic   securityLocked,
	output logic        cmdAccepted,
	output logic [15:0] actionCode,
	output logic [15:0] functionCode,
	output logic        dataPending
);
	initial
	begin
		if (DATA_SECTORS < 1 || DATA_SECTORS > 65535)
			$error("DATA_SECTORS out of range");
	end

	typedef enum logic [1:0] {LCTD_IDLE = 2'b00, LCTD_PKT = 2'b01, LCTD_RESP = 2'b11} lctd_state_e;

	////////////////////////////////////////////////////////////////////////
	// Decoding
	function automatic logic isSmartIssue(input logic [7:0] c, f, input logic [15:0] n, lo, mi, hi);
		isSmartIssue = c == lct_pkg::CMD_SMART && f == lct_pkg::FEAT_SMART_WR && n[7:0] == lct_pkg::ONE_SECTOR
			&& lo[7:0] == lct_pkg::PAGE_CMD && mi[7:0] == lct_pkg::CYL_LO_SMART
			&& hi[7:0] == lct_pkg::CYL_HI_SMART;
	endfunction : isSmartIssue

	function automatic logic isExtIssue(input logic [7:0] c, input logic [15:0] n, lo, mi);
		isExtIssue = c == lct_pkg::CMD_WRLOGEXT && n == {lct_pkg::ZERO_BYTE, lct_pkg::ONE_SECTOR}
			&& lo[7:0] == lct_pkg::PAGE_CMD && mi == {lct_pkg::ZERO_BYTE, lct_pkg::ZERO_BYTE};
	endfunction : isExtIssue

	function automatic logic isDataXfer(input logic [7:0] c, f, input logic [15:0] lo);
		isDataXfer = lo[7:0] == lct_pkg::PAGE_DATA && (c == lct_pkg::CMD_WRLOGEXT
			|| c == lct_pkg::CMD_RDLOGEXT || (c == lct_pkg::CMD_SMART
			&& (f == lct_pkg::FEAT_SMART_WR || f == lct_pkg::FEAT_SMART_RD)));
	endfunction : isDataXfer

	logic [7:0] secLocked1_r, secLocked2_r;
	lctd_state_e state_r, state_nxt;
	logic [7:0]  wordCnt_r, wordCnt_nxt;
	logic [15:0] act_r, act_nxt, fun_r, fun_nxt;
	logic        pend_r, pend_nxt, ext_r, ext_nxt, ok_r, ok_nxt;
	logic [15:0] xs_r, xs_nxt, left_r, left_nxt;
	logic        rv_r, rv_nxt;
	logic        cmdAcc_r, cmdAcc_nxt;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			secLocked1_r <= 8'h00;
			secLocked2_r <= 8'h00;
		end
		else
		begin
			secLocked1_r <= {7'h00, securityLocked};
			secLocked2_r <= secLocked1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command sequencing
	always_comb
	begin
		state_nxt   = state_r;
		wordCnt_nxt = wordCnt_r;
		act_nxt     = act_r;
		fun_nxt     = fun_r;
		pend_nxt    = pend_r;
		ext_nxt     = ext_r;
		ok_nxt      = ok_r;
		xs_nxt      = xs_r;
		left_nxt    = left_r;
		rv_nxt      = 1'b0;
		cmdAcc_nxt  = 1'b0;
		case (state_r)
			LCTD_IDLE:
			begin
				if (link.cmdValid)
				begin
					ext_nxt = link.tfCommand != lct_pkg::CMD_SMART;
					if (isSmartIssue(link.tfCommand, link.tfFeature, link.tfCount, link.tfLbaLow,
						link.tfLbaMid, link.tfLbaHigh) || isExtIssue(link.tfCommand, link.tfCount,
						link.tfLbaLow, link.tfLbaMid))
					begin
						state_nxt   = LCTD_PKT;
						wordCnt_nxt = 8'h00;
					end
					else if (isDataXfer(link.tfCommand, link.tfFeature, link.tfLbaLow))
					begin
						// Standard commands in between leave pend_r alone
						state_nxt = LCTD_RESP;
						ok_nxt    = pend_r;
						xs_nxt    = pend_r ? lct_pkg::XS_OK : lct_pkg::XS_NO_CMD;
						left_nxt  = pend_r ? left_r - 16'h0001 : 16'h0000;
						pend_nxt  = pend_r && left_r != 16'h0001;
					end
				end
			end
			LCTD_PKT:
			begin
				if (link.wordValid)
				begin
					if (wordCnt_r == 8'(lct_pkg::ACTION_WORD))
						act_nxt = link.wordData;
					if (wordCnt_r == 8'(lct_pkg::FUNCTION_WORD))
						fun_nxt = link.wordData;
					wordCnt_nxt = wordCnt_r + 8'h01;
					if (wordCnt_r == 8'(lct_pkg::PACKET_WORDS - 1))
					begin
						state_nxt = LCTD_RESP;
						left_nxt  = 16'h0000;
						if (secLocked2_r[0])
						begin
							ok_nxt = 1'b0;
							xs_nxt = lct_pkg::XS_LOCKED;
						end
						else if (pend_r)
						begin
							ok_nxt = 1'b0;
							xs_nxt = lct_pkg::XS_NESTED;
						end
						else if (act_r == 16'h0000 || (act_r > lct_pkg::ACT_MAX_STD
							&& act_r < lct_pkg::ACT_VENDOR_LO))
						begin
							ok_nxt = 1'b0;
							xs_nxt = lct_pkg::XS_BAD_ACTION;
						end
						else
						begin
							ok_nxt = 1'b1;
							xs_nxt = lct_pkg::XS_OK;
							if (act_r == lct_pkg::ACT_WRITE_SAME || act_r == lct_pkg::ACT_DATA_TABLE)
							begin
								pend_nxt = 1'b1;
								left_nxt = 16'(DATA_SECTORS);
							end
						end
					end
				end
			end
			LCTD_RESP:
			begin
				rv_nxt    = 1'b1;
				cmdAcc_nxt = ok_r;
				state_nxt = LCTD_IDLE;
			end
			default:
				state_nxt = LCTD_IDLE;
		endcase
		if (link.devReset)
		begin
			// Silent abort, nothing reported afterwards
			state_nxt = LCTD_IDLE;
			pend_nxt  = 1'b0;
			left_nxt  = 16'h0000;
			rv_nxt    = 1'b0;
			cmdAcc_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r   <= LCTD_IDLE;
			wordCnt_r <= 8'h00;
			act_r     <= 16'h0000;
			fun_r     <= 16'h0000;
			pend_r    <= 1'b0;
			ext_r     <= 1'b0;
			ok_r      <= 1'b0;
			xs_r      <= 16'h0000;
			left_r    <= 16'h0000;
			rv_r      <= 1'b0;
			cmdAcc_r  <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			wordCnt_r <= wordCnt_nxt;
			act_r     <= act_nxt;
			fun_r     <= fun_nxt;
			pend_r    <= pend_nxt;
			ext_r     <= ext_nxt;
			ok_r      <= ok_nxt;
			xs_r      <= xs_nxt;
			left_r    <= left_nxt;
			rv_r      <= rv_nxt;
			cmdAcc_r  <= cmdAcc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Response task file
	always_comb
	begin
		link.respValid = rv_r;
		link.rsError   = ok_r ? 8'h00 : lct_pkg::ERR_ABORT;
		link.rsStatus  = ok_r ? lct_pkg::STAT_OK : lct_pkg::STAT_ERR;
		// Result on success, extended status on error; both are xs_r
		link.rsCount   = {8'h00, xs_r[7:0]};
		link.rsLbaLow  = {8'h00, xs_r[15:8]};
		link.rsLbaMid  = {8'h00, left_r[7:0]};
		link.rsLbaHigh = {8'h00, left_r[15:8]};
	end

	assign cmdAccepted  = cmdAcc_r;
	assign actionCode   = act_r;
	assign functionCode = fun_r;
	assign dataPending  = pend_r;
endmodule : lct_device
`default_nettype wire

// [lct_pkg.sv]
// Constants shared by both ends of the log command transport link.
// Assumes a single 20 MHz clock shared by host end and device end.
// Contract
// - Non-data commands interleave freely with anything
// - Host finishes data phase before next command
// - Plain reads/writes may sit between data transfers
// - Any reset terminates an executing command
// - No indication of termination after reset
// - Command packet of 512 bytes to page E0h
// - SMART issue uses fixed task-file values
// - Success returns error 00h, status 50h
// - Failure returns error 04h, status 51h
// - SMART success result in count/number
// - Sectors remaining in cylinder low/high
// - SMART error extended status in count/number
// - Extended issue uses fixed task-file values
// - Extended responses use current halves only
// - Locked security fails every command; code checks the lock only at packet end, not on data transfers
// - Action code bytes 1:0, function 3:2
// - Data transfer without command gives 000Bh
package lct_pkg;
	localparam logic [7:0]  CMD_SMART      = 8'hb0;
	localparam logic [7:0]  CMD_WRLOGEXT   = 8'h3f;
	localparam logic [7:0]  CMD_RDLOGEXT   = 8'h2f;
	localparam logic [7:0]  FEAT_SMART_WR  = 8'hd6;
	localparam logic [7:0]  FEAT_SMART_RD  = 8'hd5;
	localparam logic [7:0]  CYL_LO_SMART   = 8'h4f;
	localparam logic [7:0]  CYL_HI_SMART   = 8'hc2;
	localparam logic [7:0]  PAGE_CMD       = 8'he0;
	localparam logic [7:0]  PAGE_DATA      = 8'he1;
	localparam logic [7:0]  ONE_SECTOR     = 8'h01;
	localparam logic [7:0]  ZERO_BYTE      = 8'h00;
	localparam logic [7:0]  STAT_OK        = 8'h50;
	localparam logic [7:0]  STAT_ERR       = 8'h51;
	localparam logic [7:0]  ERR_ABORT      = 8'h04;
	localparam logic [15:0] XS_OK          = 16'h0000;
	localparam logic [15:0] XS_BAD_ACTION  = 16'h0010;
	localparam logic [15:0] XS_NO_CMD      = 16'h000b;
	localparam logic [15:0] XS_LOCKED      = 16'h0012;
	localparam logic [15:0] XS_NESTED      = 16'h0003;
	localparam int          PACKET_WORDS   = 256;
	localparam int          ACTION_WORD    = 0;
	localparam int          FUNCTION_WORD  = 1;
	localparam logic [15:0] ACT_WRITE_SAME = 16'h0002;
	localparam logic [15:0] ACT_DATA_TABLE = 16'h0005;
	localparam logic [15:0] ACT_MAX_STD    = 16'h0005;
	localparam logic [15:0] ACT_VENDOR_LO  = 16'hc000;
	// APB register offsets of the host end
	localparam logic [7:0]  OFS_CMD        = 8'h00;
	localparam logic [7:0]  OFS_ARG        = 8'h04;
	localparam logic [7:0]  OFS_RESULT     = 8'h08;
	localparam logic [7:0]  OFS_IRQ_STAT   = 8'h0c;
	localparam logic [7:0]  OFS_IRQ_MASK   = 8'h10;
	localparam logic [7:0]  OFS_STATE      = 8'h14;
	localparam int          IRQ_DONE       = 0;
	localparam int          IRQ_FAIL       = 1;
	localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;
	// Host orders in OFS_CMD bits 1:0
	localparam logic [1:0]  ORD_SMART      = 2'h0;
	localparam logic [1:0]  ORD_EXT        = 2'h1;
	localparam logic [1:0]  ORD_DATA       = 2'h2;
	localparam logic [1:0]  ORD_RESET      = 2'h3;
endpackage : lct_pkg

// [lct_link_if.sv]
// Task-file link between host controller end and device end.
// Assumes both ends on mclk; one command issued at a time.
`timescale 1ns/1ps
`default_nettype none
interface lct_link_if;
	logic        cmdValid;   // One-cycle pulse: task file below valid
	logic [7:0]  tfCommand;
	logic [7:0]  tfFeature;
	logic [15:0] tfCount;    // Previous half in 15:8
	logic [15:0] tfLbaLow;
	logic [15:0] tfLbaMid;
	logic [15:0] tfLbaHigh;
	logic [7:0]  tfDevice;
	logic        wordValid;  // Packet word beat
	logic [15:0] wordData;
	logic        devReset;   // One-cycle pulse: any reset type
	logic        respValid;  // One-cycle pulse
	logic [7:0]  rsError;
	logic [7:0]  rsStatus;
	logic [15:0] rsCount;
	logic [15:0] rsLbaLow;
	logic [15:0] rsLbaMid;
	logic [15:0] rsLbaHigh;
	modport host (output cmdValid, tfCommand, tfFeature, tfCount, tfLbaLow, tfLbaMid, tfLbaHigh,
		tfDevice, wordValid, wordData, devReset,
		input respValid, rsError, rsStatus, rsCount, rsLbaLow, rsLbaMid, rsLbaHigh);
	modport dev (input cmdValid, tfCommand, tfFeature, tfCount, tfLbaLow, tfLbaMid, tfLbaHigh,
		tfDevice, wordValid, wordData, devReset,
		output respValid, rsError, rsStatus, rsCount, rsLbaLow, rsLbaMid, rsLbaHigh);
endinterface : lct_link_if
`default_nettype wire

// [lct_host.sv]
// Host end: APB-controlled issuer of transport commands and packet words.
// Assumes a single mclk domain with the device end.
`timescale 1ns/1ps
`default_nettype none
module lct_host (
	input  wire logic   mclk,
	input  wire logic   rst_b,
	lct_link_if.host    link,
	input  wire logic   psel,
	input  wire logic   penable,
	input  wire logic   pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	output logic        irq
);
	typedef enum logic [1:0] {LCTH_IDLE = 2'b00, LCTH_ISSUE = 2'b01, LCTH_WORDS = 2'b11, LCTH_WAIT = 2'b10} lcth_state_e;

	lcth_state_e state_r, state_nxt;
	logic [31:0] arg_r, arg_nxt, res_r, res_nxt, rd_r, rd_nxt;
	logic [1:0]  ord_r, ord_nxt, stat_r, stat_nxt, mask_r, mask_nxt;
	logic [7:0]  wc_r, wc_nxt;
	logic        rdy_r, rdy_nxt, err_r, err_nxt, irq_r, irq_nxt, cv_r, cv_nxt, wv_r, wv_nxt, rst_r, rst_nxt;
	logic        acc;

	always_comb
	begin
		acc       = psel && penable && !rdy_r;
		state_nxt = state_r;
		arg_nxt   = arg_r;
		res_nxt   = res_r;
		rd_nxt    = rd_r;
		ord_nxt   = ord_r;
		stat_nxt  = stat_r;
		mask_nxt  = mask_r;
		wc_nxt    = wc_r;
		rdy_nxt   = acc;
		err_nxt   = 1'b0;
		cv_nxt    = 1'b0;
		wv_nxt    = 1'b0;
		rst_nxt   = 1'b0;
		if (acc && pwrite)
		begin
			case (paddr)
				lct_pkg::OFS_CMD:
				begin
					if (pwdata[1:0] == lct_pkg::ORD_RESET)
						rst_nxt = 1'b1;
					else if (state_r == LCTH_IDLE)
					begin
						ord_nxt   = pwdata[1:0];
						state_nxt = LCTH_ISSUE;
					end
					else
						err_nxt = 1'b1;
				end
				lct_pkg::OFS_ARG:      arg_nxt  = pwdata;
				lct_pkg::OFS_IRQ_MASK: mask_nxt = pwdata[1:0];
				lct_pkg::OFS_IRQ_STAT: ;
				default:               err_nxt = 1'b1;
			endcase
		end
		if (acc && !pwrite)
		begin
			case (paddr)
				lct_pkg::OFS_CMD:      rd_nxt = {30'h0, ord_r};
				lct_pkg::OFS_ARG:      rd_nxt = arg_r;
				lct_pkg::OFS_RESULT:   rd_nxt = res_r;
				lct_pkg::OFS_IRQ_STAT: rd_nxt = {30'h0, stat_r};
				lct_pkg::OFS_IRQ_MASK: rd_nxt = {30'h0, mask_r};
				lct_pkg::OFS_STATE:    rd_nxt = {30'h0, state_r};
				default:
				begin
					rd_nxt  = 32'h0;
					err_nxt = 1'b1;
				end
			endcase
			if (paddr == lct_pkg::OFS_IRQ_STAT)
				stat_nxt = 2'h0;
		end
		case (state_r)
			LCTH_IDLE: ;
			LCTH_ISSUE:
			begin
				cv_nxt    = 1'b1;
				wc_nxt    = 8'h00;
				state_nxt = ord_r == lct_pkg::ORD_DATA ? LCTH_WAIT : LCTH_WORDS;
			end
			LCTH_WORDS:
			begin
				wv_nxt = 1'b1;
				wc_nxt = wc_r + 8'h01;
				if (wc_r == 8'(lct_pkg::PACKET_WORDS - 1))
					state_nxt = LCTH_WAIT;
			end
			LCTH_WAIT:
			begin
				if (link.respValid)
				begin
					res_nxt   = {link.rsStatus, link.rsError, link.rsLbaLow[7:0], link.rsCount[7:0]};
					state_nxt = LCTH_IDLE;
					stat_nxt[lct_pkg::IRQ_DONE] = 1'b1;
					stat_nxt[lct_pkg::IRQ_FAIL] = link.rsStatus == lct_pkg::STAT_ERR;
				end
			end
			default: state_nxt = LCTH_IDLE;
		endcase
		if (rst_r)
		begin
			// A cut packet stops at once
			state_nxt = LCTH_IDLE;
			cv_nxt    = 1'b0;
			wv_nxt    = 1'b0;
		end
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= LCTH_IDLE;
			arg_r   <= 32'h0;
			res_r   <= 32'h0;
			rd_r    <= 32'h0;
			ord_r   <= 2'h0;
			stat_r  <= 2'h0;
			mask_r  <= lct_pkg::IRQ_MASK_RST;
			wc_r    <= 8'h00;
			rdy_r   <= 1'b0;
			err_r   <= 1'b0;
			irq_r   <= 1'b0;
			cv_r    <= 1'b0;
			wv_r    <= 1'b0;
			rst_r   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			arg_r   <= arg_nxt;
			res_r   <= res_nxt;
			rd_r    <= rd_nxt;
			ord_r   <= ord_nxt;
			stat_r  <= stat_nxt;
			mask_r  <= mask_nxt;
			wc_r    <= wc_nxt;
			rdy_r   <= rdy_nxt;
			err_r   <= err_nxt;
			irq_r   <= irq_nxt;
			cv_r    <= cv_nxt;
			wv_r    <= wv_nxt;
			rst_r   <= rst_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Task file drive
	always_comb
	begin
		link.cmdValid  = cv_r;
		link.devReset  = rst_r;
		link.tfDevice  = {3'h0, arg_r[4], 4'h0};
		link.wordValid = wv_r;
		link.wordData  = wc_r == 8'h01 ? arg_r[15:0] : (wc_r == 8'h02 ? arg_r[31:16] : 16'h0000);
		link.tfLbaLow  = {8'h00, ord_r == lct_pkg::ORD_DATA ? lct_pkg::PAGE_DATA : lct_pkg::PAGE_CMD};
		if (ord_r == lct_pkg::ORD_SMART)
		begin
			link.tfCommand = lct_pkg::CMD_SMART;
			link.tfFeature = lct_pkg::FEAT_SMART_WR;
			link.tfCount   = {8'h00, lct_pkg::ONE_SECTOR};
			link.tfLbaMid  = {8'h00, lct_pkg::CYL_LO_SMART};
			link.tfLbaHigh = {8'h00, lct_pkg::CYL_HI_SMART};
		end
		else
		begin
			link.tfCommand = lct_pkg::CMD_WRLOGEXT;
			link.tfFeature = 8'h00;
			link.tfCount   = {lct_pkg::ZERO_BYTE, lct_pkg::ONE_SECTOR};
			link.tfLbaMid  = 16'h0000;
			link.tfLbaHigh = 16'h0000;
		end
	end

	assign prdata  = rd_r;
	assign pready  = rdy_r;
	assign pslverr = err_r;
	assign irq     = irq_r;
endmodule : lct_host
`default_nettype wire

// [lct_chk.sv]
// Checker for the task-file link between host end and device end.
// Assumes it is instantiated beside the interface, on mclk, rst_b.
`timescale 1ns/1ps
`default_nettype none
module lct_chk (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        cmdValid,
	input wire logic [7:0]  tfCommand,
	input wire logic [7:0]  tfFeature,
	input wire logic [15:0] tfCount,
	input wire logic [15:0] tfLbaLow,
	input wire logic [15:0] tfLbaMid,
	input wire logic [15:0] tfLbaHigh,
	input wire logic        wordValid,
	input wire logic        devReset,
	input wire logic        respValid,
	input wire logic [7:0]  rsError,
	input wire logic [7:0]  rsStatus,
	input wire logic [15:0] rsCount,
	input wire logic [15:0] rsLbaLow,
	input wire logic [15:0] rsLbaMid,
	input wire logic [15:0] rsLbaHigh
);
	logic [8:0] beats_r;
	logic [8:0] beats_nxt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////
	// Packet words seen since the last command
	always_comb
	begin
		beats_nxt = beats_r;
		if (cmdValid)
			beats_nxt = 9'h000;
		else if (wordValid)
			beats_nxt = beats_r + 9'h001;
	end
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			beats_r <= 9'h000;
		else
			beats_r <= beats_nxt;
	////////////////////////////////////////////////////////////////
	AST_SMART_TF: assert property (cmdValid && tfCommand == lct_pkg::CMD_SMART && tfLbaLow[7:0] == lct_pkg::PAGE_CMD
		|-> tfFeature == 8'hd6 && tfCount[7:0] == 8'h01 && tfLbaMid[7:0] == 8'h4f && tfLbaHigh[7:0] == 8'hc2)
		else $error("SMART task file wrong");
	AST_EXT_TF: assert property (cmdValid && tfCommand == 8'h3f && tfLbaLow[7:0] == lct_pkg::PAGE_CMD
		|-> tfCount == 16'h0001 && tfLbaMid == 16'h0000) else $error("extended task file wrong");
	AST_PKT_LEN: assert property (respValid |-> beats_r == 9'h000 || beats_r == 9'h100)
		else $error("packet length wrong");
	AST_PKT_BEATS: assert property (cmdValid && tfLbaLow[7:0] == lct_pkg::PAGE_CMD |=> wordValid [*8])
		else $error("packet words not consecutive");
	AST_RESP_CODES: assert property (respValid |-> (rsError == 8'h00 && rsStatus == 8'h50)
		|| (rsError == 8'h04 && rsStatus == 8'h51)) else $error("response codes wrong");
	AST_PREV_HALF: assert property (respValid |-> {rsCount[15:8], rsLbaLow[15:8], rsLbaMid[15:8],
		rsLbaHigh[15:8]} == 32'h0) else $error("previous halves not clear");
	AST_RESP_AFTER_PKT: assert property ($fell(wordValid) |-> ##[1:2] respValid)
		else $error("no response after packet");
	AST_DATA_RESP: assert property (cmdValid && tfLbaLow[7:0] == lct_pkg::PAGE_DATA |-> ##2 respValid)
		else $error("no response to data transfer");
	AST_RESET_SILENT: assert property (devReset |=> (!respValid && !wordValid) [*3])
		else $error("activity after reset");
	AST_RESP_PULSE: assert property (respValid |=> !respValid)
		else $error("response longer than one cycle");
	cover property (respValid && rsError == lct_pkg::ERR_ABORT);
	cover property (devReset);
	cover property (respValid && rsStatus == lct_pkg::STAT_OK);
	cover property (cmdValid && tfCommand == lct_pkg::CMD_WRLOGEXT);
endmodule : lct_chk
`default_nettype wire

// [tb_log_page_command_transport.sv]
// Testbench: host end and device end joined, host end driven over APB.
// Assumes the design files and lct_chk.sv are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_log_page_command_transport;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        securityLocked = 1'b0;
	logic [15:0] actionCode;
	logic [15:0] functionCode;
	logic        dataPending;
	logic        cmdAccepted;
	int          accepts = 0;
	int          failures = 0;
	int          total_checks = 0;
	lct_link_if lnk ();
	lct_host i_lct_host (.mclk(mclk), .rst_b(rst_b), .link(lnk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));
	lct_device i_lct_device (.mclk(mclk), .rst_b(rst_b), .link(lnk), .securityLocked(securityLocked),
		.cmdAccepted(cmdAccepted), .actionCode(actionCode), .functionCode(functionCode),
		.dataPending(dataPending));
	lct_chk i_lct_chk (.mclk(mclk), .rst_b(rst_b), .cmdValid(lnk.cmdValid), .tfCommand(lnk.tfCommand),
		.tfFeature(lnk.tfFeature), .tfCount(lnk.tfCount), .tfLbaLow(lnk.tfLbaLow), .tfLbaMid(lnk.tfLbaMid),
		.tfLbaHigh(lnk.tfLbaHigh), .wordValid(lnk.wordValid), .devReset(lnk.devReset),
		.respValid(lnk.respValid), .rsError(lnk.rsError), .rsStatus(lnk.rsStatus), .rsCount(lnk.rsCount),
		.rsLbaLow(lnk.rsLbaLow), .rsLbaMid(lnk.rsLbaMid), .rsLbaHigh(lnk.rsLbaHigh));
	initial
	begin
		forever #25 mclk = ~mclk;
	end
	// Accepted-command pulses seen
	always @(posedge mclk)
		if (cmdAccepted === 1'b1)
			accepts <= accepts + 1;
	////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("Checks %0d, failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (exp !== got)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask : chk
	// One APB transfer; for reads d is the expected data
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			failures++;
			conclude();
		end
		if (!w)
			chk("prdata", d, prdata);
		chk("pslverr", {31'h0, e}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Await the link answer, check result and interrupt
	task automatic collect(input logic ok, input logic [15:0] xs, input logic irqExp);
		int n;
		n = 0;
		while (lnk.respValid !== 1'b1 && n < 400)
		begin
			@(posedge mclk);
			n++;
		end
		if (n >= 400)
		begin
			failures++;
			conclude();
		end
		repeat (2) @(posedge mclk);
		chk("irq", {31'h0, irqExp}, {31'h0, irq});
		if (ok)
			apb(1'b0, lct_pkg::OFS_RESULT, {lct_pkg::STAT_OK, 8'h00, xs}, 1'b0);
		else
			apb(1'b0, lct_pkg::OFS_RESULT, {lct_pkg::STAT_ERR, lct_pkg::ERR_ABORT, xs}, 1'b0);
		apb(1'b0, lct_pkg::OFS_IRQ_STAT, {30'h0, !ok, 1'b1}, 1'b0);
		apb(1'b0, lct_pkg::OFS_IRQ_STAT, 32'h0, 1'b0);
	endtask : collect
	// Issue one order and collect its answer
	task automatic run(input logic [1:0] ord, input logic ok, input logic [15:0] xs, input logic irqExp);
		apb(1'b1, lct_pkg::OFS_CMD, {30'h0, ord}, 1'b0);
		collect(ok, xs, irqExp);
	endtask : run
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		apb(1'b0, lct_pkg::OFS_IRQ_MASK, 32'h0, 1'b0);
		apb(1'b0, lct_pkg::OFS_IRQ_STAT, 32'h0, 1'b0);
		apb(1'b0, 8'h40, 32'h0, 1'b1);
		$display("Test reset values and map done");
		apb(1'b1, lct_pkg::OFS_IRQ_MASK, 32'h3, 1'b0);
		apb(1'b1, lct_pkg::OFS_ARG, 32'h5678_1234, 1'b0);
		run(lct_pkg::ORD_SMART, 1'b0, lct_pkg::XS_BAD_ACTION, 1'b1);
		chk("function", 32'h5678, {16'h0, functionCode});
		chk("action", 32'h1234, {16'h0, actionCode});
		run(lct_pkg::ORD_EXT, 1'b0, lct_pkg::XS_BAD_ACTION, 1'b1);
		apb(1'b1, lct_pkg::OFS_CMD, {30'h0, lct_pkg::ORD_EXT}, 1'b0);
		apb(1'b1, lct_pkg::OFS_CMD, {30'h0, lct_pkg::ORD_SMART}, 1'b1);
		collect(1'b0, lct_pkg::XS_BAD_ACTION, 1'b1);
		$display("Test both issue forms done");
		run(lct_pkg::ORD_DATA, 1'b0, lct_pkg::XS_NO_CMD, 1'b1);
		chk("pending", 32'h0, {31'h0, dataPending});
		$display("Test data without command done");
		apb(1'b1, lct_pkg::OFS_ARG, 32'h0001_0004, 1'b0);
		run(lct_pkg::ORD_SMART, 1'b1, lct_pkg::XS_OK, 1'b1);
		chk("pending", 32'h0, {31'h0, dataPending});
		apb(1'b1, lct_pkg::OFS_ARG, 32'h0001_0002, 1'b0);
		run(lct_pkg::ORD_EXT, 1'b1, lct_pkg::XS_OK, 1'b1);
		chk("pending", 32'h1, {31'h0, dataPending});
		run(lct_pkg::ORD_DATA, 1'b1, lct_pkg::XS_OK, 1'b1);
		chk("pending", 32'h0, {31'h0, dataPending});
		$display("Test data phase done");
		run(lct_pkg::ORD_SMART, 1'b1, lct_pkg::XS_OK, 1'b1);
		run(lct_pkg::ORD_EXT, 1'b0, lct_pkg::XS_NESTED, 1'b1);
		chk("pending", 32'h1, {31'h0, dataPending});
		apb(1'b1, lct_pkg::OFS_CMD, {30'h0, lct_pkg::ORD_RESET}, 1'b0);
		repeat (20) @(posedge mclk);
		chk("pending", 32'h0, {31'h0, dataPending});
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b0, lct_pkg::OFS_IRQ_STAT, 32'h0, 1'b0);
		run(lct_pkg::ORD_DATA, 1'b0, lct_pkg::XS_NO_CMD, 1'b1);
		$display("Test nesting and link reset done");
		apb(1'b1, lct_pkg::OFS_ARG, 32'h0001_0004, 1'b0);
		securityLocked <= 1'b1;
		repeat (4) @(posedge mclk);
		run(lct_pkg::ORD_SMART, 1'b0, lct_pkg::XS_LOCKED, 1'b1);
		securityLocked <= 1'b0;
		repeat (4) @(posedge mclk);
		$display("Test security lock done");
		apb(1'b1, lct_pkg::OFS_IRQ_MASK, 32'h0, 1'b0);
		run(lct_pkg::ORD_SMART, 1'b1, lct_pkg::XS_OK, 1'b0);
		chk("accepts", 32'd5, accepts);
		$display("Test interrupt mask done");
		conclude();
	end
endmodule : tb_log_page_command_transport
`default_nettype wire
